// [src/dbg_consts.vh]
// Constants for the core breakpoint debug unit
`ifndef DBG_CONSTS_VH
`define DBG_CONSTS_VH

// ********************************************************
// Register byte offsets
// ********************************************************
`define OFS_BREAK_CONTROL   8'h00
`define OFS_BREAK_STATUS    8'h04
`define OFS_CORE_INDEX      8'h08
`define OFS_DECODE1_ADDR    8'h0c
`define OFS_DECODE2_ADDR    8'h10
`define OFS_BAD_OPCODE      8'h14
// Range pairs: start at base + 8*k, end at base + 8*k + 4
`define OFS_RANGE_BASE      8'h40
`define RANGE_WORDS         18

// ********************************************************
// Break control fields
// ********************************************************
`define BC_SLAVE1_EN        27
`define BC_SLAVE2_EN        26
`define BC_USER_QUALIFY     25
`define BC_COMBINE_ALL      24
`define BC_INSTR_EN         21
`define BC_DATA_EN          20
`define BC_PROGMEM_EN       19
`define BC_SLAVE_INV        17
`define BC_INSTR4_INV       16
`define BC_INSTR1_INV       13
`define BC_DATA2_INV        12
`define BC_DATA1_INV        11
`define BC_PROGMEM_INV      10
`define BC_SLAVE_TRIG_HI    7
`define BC_SLAVE_TRIG_LO    6
`define BC_DATA2_TRIG_HI    5
`define BC_DATA2_TRIG_LO    4
`define BC_DATA1_TRIG_HI    3
`define BC_DATA1_TRIG_LO    2
`define BC_PROG_TRIG_HI     1
`define BC_PROG_TRIG_LO     0
`define BC_WRITE_MASK       32'h0f3bfcff
`define BC_RESET            32'h00000000

// ********************************************************
// Break status fields and bad opcode layout
// ********************************************************
`define BS_SLAVE2_HIT       16
`define BS_SLAVE1_HIT       7
`define BAD_ATOMIC_BIT      24
`define BAD_ADDR_HI         23
`define INSTR_ADDR_MASK     32'h00ffffff
`define BS_RESET            32'h00000000
`define BAD_RESET           32'h00000000
`define RANGE_RESET         32'h00000000

// ********************************************************
// AXI responses
// ********************************************************
`define RESP_OKAY           2'b00
`define RESP_SLVERR         2'b10

`endif

// [src/core_breakpoint_debug_unit.v]
// Breakpoint debug unit with AXI4-Lite register slave
`timescale 1ns/1ps
`default_nettype none
`include "dbg_consts.vh"

module core_breakpoint_debug_unit #(
  parameter [31:0] CORE_INDEX = 32'h00000000,
  parameter        ADDR_W     = 8
) (
  input  wire              aclk,
  input  wire              aresetn,

  // Register bus, write side
  input  wire [ADDR_W-1:0] s_axi_awaddr,
  input  wire [2:0]        s_axi_awprot,
  input  wire              s_axi_awvalid,
  output wire              s_axi_awready,
  input  wire [31:0]       s_axi_wdata,
  input  wire [3:0]        s_axi_wstrb,
  input  wire              s_axi_wvalid,
  output wire              s_axi_wready,
  output wire [1:0]        s_axi_bresp,
  output wire              s_axi_bvalid,
  input  wire              s_axi_bready,

  // Register bus, read side
  input  wire [ADDR_W-1:0] s_axi_araddr,
  input  wire [2:0]        s_axi_arprot,
  input  wire              s_axi_arvalid,
  output wire              s_axi_arready,
  output wire [31:0]       s_axi_rdata,
  output wire [1:0]        s_axi_rresp,
  output wire              s_axi_rvalid,
  input  wire              s_axi_rready,

  // Monitored core buses
  input  wire [23:0]       instr_addr,
  input  wire              instr_valid,
  input  wire [31:0]       data_mem_addr,
  input  wire              data_valid,
  input  wire              data_write,
  input  wire [31:0]       prog_mem_data_addr,
  input  wire              progmem_valid,
  input  wire              progmem_write,
  input  wire [31:0]       slave1_addr,
  input  wire              slave1_valid,
  input  wire              slave1_write,
  input  wire [31:0]       slave2_addr,
  input  wire              slave2_valid,
  input  wire              slave2_write,

  // Core state and taps
  input  wire              user_mode,
  input  wire [31:0]       decode1_addr,
  input  wire [31:0]       decode2_addr,
  input  wire              bad_opcode_irq,
  input  wire [23:0]       bad_opcode_pc,
  input  wire              atomic_active,

  // Break request
  output wire              break_req
);

  // ********************************************************
  // Register state
  // ********************************************************
  reg  [31:0]       break_control_r;
  reg  [31:0]       break_status_r;
  reg  [31:0]       bad_opcode_capture_r;
  reg  [31:0]       decode1_r;
  reg  [31:0]       decode2_r;
  reg  [31:0]       range_r [0:`RANGE_WORDS-1];
  reg               break_req_r;

  // One write, one read
  reg               aw_held_r;
  reg               w_held_r;
  reg  [ADDR_W-1:0] awaddr_r;
  reg  [31:0]       wdata_r;
  reg  [3:0]        wstrb_r;
  reg               bvalid_r;
  reg  [1:0]        bresp_r;
  reg               rvalid_r;
  reg  [31:0]       rdata_r;
  reg  [1:0]        rresp_r;

  // Trigger select: 01 reads, 10 writes, 11 both, 00 never
  // Not used by instruction units
  function trig_ok;
    input [1:0] sel;
    input       valid;
    input       is_write;
    begin
      trig_ok = valid & ((sel[0] & ~is_write) | (sel[1] & is_write));
    end
  endfunction

  // Byte-lane merge of a write onto an old value
  // Strobes honoured per lane
  function [31:0] merge;
    input [31:0] old;
    input [31:0] data;
    input [3:0]  strb;
    integer      i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i])
          merge[i*8 +: 8] = data[i*8 +: 8];
      end
    end
  endfunction

  // ********************************************************
  // AXI write channel acceptance
  // ********************************************************
  // Address and data taken in either order, held until both
  wire              aw_take  = s_axi_awvalid & s_axi_awready;
  wire              w_take   = s_axi_wvalid & s_axi_wready;
  wire              aw_have  = aw_held_r | aw_take;
  wire              w_have   = w_held_r | w_take;
  wire              wr_fire  = aw_have & w_have;
  wire [ADDR_W-1:0] wr_addr  = aw_held_r ? awaddr_r : s_axi_awaddr;
  wire [31:0]       wr_data  = w_held_r ? wdata_r : s_axi_wdata;
  wire [3:0]        wr_strb  = w_held_r ? wstrb_r : s_axi_wstrb;

  // Ready drops while a half waits
  assign s_axi_awready = ~aw_held_r & ~bvalid_r;
  assign s_axi_wready  = ~w_held_r & ~bvalid_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;

  // Read side
  assign s_axi_arready = ~rvalid_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;

  // Break from a flop
  assign break_req     = break_req_r;

  // Range window decode, shared by read and write paths
  wire [ADDR_W-1:0] wr_rofs = wr_addr - `OFS_RANGE_BASE;
  wire [ADDR_W-1:0] rd_rofs = s_axi_araddr - `OFS_RANGE_BASE;
  wire              wr_in_range = (wr_addr >= `OFS_RANGE_BASE) &&
                      (wr_rofs[ADDR_W-1:2] < `RANGE_WORDS);
  wire              rd_in_range = (s_axi_araddr >= `OFS_RANGE_BASE) &&
                      (rd_rofs[ADDR_W-1:2] < `RANGE_WORDS);
  // Word index in the window
  wire [4:0]        wr_idx = wr_rofs[6:2];
  wire [4:0]        rd_idx = rd_rofs[6:2];

  // Other offsets give SLVERR
  wire wr_ctl = wr_fire & (wr_addr == `OFS_BREAK_CONTROL);
  wire wr_bad = wr_fire & (wr_addr == `OFS_BAD_OPCODE);
  wire wr_ok  = (wr_addr == `OFS_BREAK_CONTROL) |
                (wr_addr == `OFS_BAD_OPCODE) | wr_in_range;

  // ********************************************************
  // Breakpoint comparators
  // ********************************************************
  // Short alias
  wire [31:0] ctl = break_control_r;

  // Monitored address per breakpoint: 0 prog, 1-2 data,
  // 3-6 instruction, 7-8 slave ports
  // Fetch addresses zero-extended
  wire [287:0] mon_addr = {slave2_addr, slave1_addr,
                           8'h00, instr_addr, 8'h00, instr_addr,
                           8'h00, instr_addr, 8'h00, instr_addr,
                           data_mem_addr, data_mem_addr,
                           prog_mem_data_addr};

  // Qualifying access per breakpoint
  wire [1:0] slv_sel = ctl[`BC_SLAVE_TRIG_HI:`BC_SLAVE_TRIG_LO];
  wire [1:0] da2_sel = ctl[`BC_DATA2_TRIG_HI:`BC_DATA2_TRIG_LO];
  wire [1:0] da1_sel = ctl[`BC_DATA1_TRIG_HI:`BC_DATA1_TRIG_LO];
  wire [1:0] pa_sel  = ctl[`BC_PROG_TRIG_HI:`BC_PROG_TRIG_LO];

  // One filter per unit
  wire [8:0] acc_ok  = {trig_ok(slv_sel, slave2_valid, slave2_write),
                        trig_ok(slv_sel, slave1_valid, slave1_write),
                        {4{instr_valid}},
                        trig_ok(da2_sel, data_valid, data_write),
                        trig_ok(da1_sel, data_valid, data_write),
                        trig_ok(pa_sel, progmem_valid, progmem_write)};

  // Invert bits; one bit covers both slave ports
  wire [8:0] inv = {ctl[`BC_SLAVE_INV], ctl[`BC_SLAVE_INV],
                    ctl[`BC_INSTR4_INV:`BC_INSTR1_INV],
                    ctl[`BC_DATA2_INV:`BC_PROGMEM_INV]};

  // Enables; user qualify blocks all outside user mode
  wire [8:0] en_raw = {ctl[`BC_SLAVE2_EN], ctl[`BC_SLAVE1_EN],
                       {4{ctl[`BC_INSTR_EN]}},
                       {2{ctl[`BC_DATA_EN]}},
                       ctl[`BC_PROGMEM_EN]};

  // Gates every unit
  wire       user_ok = ~ctl[`BC_USER_QUALIFY] | user_mode;
  wire [8:0] en      = en_raw & {9{user_ok}};

  wire [8:0] in_rng;
  wire [8:0] hit;

  // Nine like comparators
  genvar k;
  generate
    for (k = 0; k < 9; k = k + 1) begin : g_bp
      // Inclusive window, then invert, then qualify
      assign in_rng[k] = (mon_addr[k*32 +: 32] >= range_r[2*k]) &&
                         (mon_addr[k*32 +: 32] <= range_r[2*k+1]);
      assign hit[k] = en[k] & acc_ok[k] & (in_rng[k] ^ inv[k]);
    end
  endgenerate

  // AND mode needs every enabled unit true in the same cycle
  // Nothing enabled: no break
  wire all_true = (|en) & (&(hit | ~en));
  wire brk_nxt  = ctl[`BC_COMBINE_ALL] ? all_true : (|hit);

  // Hits mapped onto status bit layout
  // Bits 15:8 stay zero
  wire [31:0] hit_bits = {15'h0000, hit[8], 8'h00,
                          hit[7:3],
                          hit[2:0]};

  // ********************************************************
  // Control, status and capture registers
  // ********************************************************
  // Nothing matches after reset since all enables clear
  always @(posedge aclk) begin
    if (!aresetn) begin
      break_control_r <= `BC_RESET;
    end else if (wr_ctl) begin
      break_control_r <= merge(break_control_r, wr_data, wr_strb) &
                         `BC_WRITE_MASK;
    end
  end

  // A control write re-arms; a hit in that cycle still lands
  // No per-bit clear
  always @(posedge aclk) begin
    if (!aresetn) begin
      break_status_r <= `BS_RESET;
      break_req_r    <= 1'b0;
    end else begin
      break_req_r <= brk_nxt;
      if (wr_ctl)
        break_status_r <= hit_bits;
      else
        break_status_r <= break_status_r | hit_bits;
    end
  end

  // Capture beats a clearing write in the same cycle
  // Write data never stored
  always @(posedge aclk) begin
    if (!aresetn) begin
      bad_opcode_capture_r <= `BAD_RESET;
    end else if (bad_opcode_irq) begin
      bad_opcode_capture_r <= {7'h00, atomic_active,
                               bad_opcode_pc};
    end else if (wr_bad) begin
      bad_opcode_capture_r <= `BAD_RESET;
    end
  end

  // Decode stage addresses registered for a clean read path
  // Costs one cycle of lag
  always @(posedge aclk) begin
    if (!aresetn) begin
      decode1_r <= 32'h00000000;
      decode2_r <= 32'h00000000;
    end else begin
      decode1_r <= decode1_addr;
      decode2_r <= decode2_addr;
    end
  end

  // Range words; instruction pairs keep only 24 bits
  // Words 6 to 13 are fetch
  integer j;
  always @(posedge aclk) begin
    if (!aresetn) begin
      for (j = 0; j < `RANGE_WORDS; j = j + 1)
        range_r[j] <= `RANGE_RESET;
    end else if (wr_fire && wr_in_range) begin
      if (wr_idx >= 5'd6 && wr_idx <= 5'd13)
        range_r[wr_idx] <= merge(range_r[wr_idx], wr_data, wr_strb) &
                           `INSTR_ADDR_MASK;
      else
        range_r[wr_idx] <= merge(range_r[wr_idx], wr_data,
                                 wr_strb);
    end
  end

  // ********************************************************
  // AXI write handshake state
  // ********************************************************
  // Response waits until both halves of the write are in
  // Held half waits here
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      w_held_r  <= 1'b0;
      awaddr_r  <= {ADDR_W{1'b0}};
      wdata_r   <= 32'h00000000;
      wstrb_r   <= 4'h0;
      bvalid_r  <= 1'b0;
      bresp_r   <= `RESP_OKAY;
    end else begin
      if (wr_fire) begin
        aw_held_r <= 1'b0;
        w_held_r  <= 1'b0;
        bvalid_r  <= 1'b1;
        bresp_r   <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
      end else begin
        if (aw_take) begin
          aw_held_r <= 1'b1;
          awaddr_r  <= s_axi_awaddr;
        end
        if (w_take) begin
          w_held_r <= 1'b1;
          wdata_r  <= s_axi_wdata;
          wstrb_r  <= s_axi_wstrb;
        end
        if (bvalid_r && s_axi_bready)
          bvalid_r <= 1'b0;
      end
    end
  end

  // ********************************************************
  // AXI read path
  // ********************************************************
  reg [31:0] rd_mux;
  reg        rd_hit;

  // Unmapped: zero, SLVERR
  always @* begin
    rd_mux = 32'h00000000;
    rd_hit = 1'b1;
    case (s_axi_araddr)
      `OFS_BREAK_CONTROL: rd_mux = break_control_r;
      `OFS_BREAK_STATUS:  rd_mux = break_status_r;
      `OFS_CORE_INDEX:    rd_mux = CORE_INDEX;
      `OFS_DECODE1_ADDR:  rd_mux = decode1_r;
      `OFS_DECODE2_ADDR:  rd_mux = decode2_r;
      `OFS_BAD_OPCODE:    rd_mux = bad_opcode_capture_r;
      default: begin
        if (rd_in_range)
          rd_mux = range_r[rd_idx];
        else
          rd_hit = 1'b0;
      end
    endcase
  end

  // One read outstanding; data held until rready
  // Reads have no side effect
  always @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h00000000;
      rresp_r  <= `RESP_OKAY;
    end else if (s_axi_arvalid && !rvalid_r) begin
      rvalid_r <= 1'b1;
      rdata_r  <= rd_mux;
      rresp_r  <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// [test/dbg_unit_properties.sv]
// Port-level checker for the breakpoint debug unit
`timescale 1ns/1ps
`default_nettype none
module dbg_unit_props (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        instr_valid,
  input wire logic        data_valid,
  input wire logic        progmem_valid,
  input wire logic        slave1_valid,
  input wire logic        slave2_valid,
  input wire logic        break_req
);
  // ********************************************************
  // Properties
  // ********************************************************
  // All checks share the core clock and its reset
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_after_reset;
    $rose(aresetn) |-> !break_req && !s_axi_bvalid && !s_axi_rvalid;
  endproperty
  a_after_reset: assert property (p_after_reset)
    else $error("output busy after reset");
  // A break needs a monitored access one cycle before
  property p_break_cause;
    break_req |-> $past(instr_valid || data_valid || progmem_valid ||
                        slave1_valid || slave2_valid);
  endproperty
  a_break_cause: assert property (p_break_cause)
    else $error("break without access");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold)
    else $error("write response dropped early");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold)
    else $error("read data dropped early");
  property p_b_after;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |=> s_axi_bvalid;
  endproperty
  a_b_after: assert property (p_b_after)
    else $error("late write response");
  property p_r_after;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid [*1];
  endproperty
  a_r_after: assert property (p_r_after)
    else $error("late read data");
  property p_ar_refuse;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_ar_refuse: assert property (p_ar_refuse)
    else $error("read address accepted while data pending");
  property p_b_done;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready;
  endproperty
  a_b_done: assert property (p_b_done)
    else $error("response not retired");
endmodule

bind core_breakpoint_debug_unit dbg_unit_props u_props (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
  .s_axi_rready, .instr_valid, .data_valid, .progmem_valid,
  .slave1_valid, .slave2_valid, .break_req);
`default_nettype wire

// [test/core_model.sv]
// Core pipeline model driving the monitored buses
`timescale 1ns/1ps
`default_nettype none
module core_model (
  input  wire logic        aclk,
  output var  logic [23:0] instr_addr,
  output var  logic        instr_valid,
  output var  logic [31:0] data_mem_addr,
  output var  logic        data_valid,
  output var  logic        data_write,
  output var  logic [31:0] prog_mem_data_addr,
  output var  logic        progmem_valid,
  output var  logic        progmem_write,
  output var  logic [31:0] slave1_addr,
  output var  logic        slave1_valid,
  output var  logic        slave1_write,
  output var  logic [31:0] slave2_addr,
  output var  logic        slave2_valid,
  output var  logic        slave2_write,
  output var  logic        user_mode,
  output var  logic [31:0] decode1_addr,
  output var  logic [31:0] decode2_addr,
  output var  logic        bad_opcode_irq,
  output var  logic [23:0] bad_opcode_pc,
  output var  logic        atomic_active
);
  // ********************************************************
  // Access tasks
  // ********************************************************
  // Quiet start; idle lines later show the inverse of the last value
  initial begin
    {instr_addr, instr_valid, data_mem_addr, data_valid, data_write,
     prog_mem_data_addr, progmem_valid, progmem_write, slave1_addr,
     slave1_valid, slave1_write, slave2_addr, slave2_valid, slave2_write,
     user_mode, decode1_addr, decode2_addr, bad_opcode_irq, bad_opcode_pc,
     atomic_active} = '0;
  end
  // One-cycle access on buses m: prog, data, instr, slave1, slave2
  task automatic access(input logic [4:0] m, input logic [31:0] a,
                        input logic w, input logic um);
    @(posedge aclk);
    {prog_mem_data_addr, data_mem_addr, slave1_addr, slave2_addr} <= {4{a}};
    instr_addr <= a[23:0];
    {slave2_valid, slave1_valid, instr_valid, data_valid, progmem_valid} <= m;
    {progmem_write, data_write, slave1_write, slave2_write} <= {4{w}};
    user_mode <= um;
    @(posedge aclk);
    {prog_mem_data_addr, data_mem_addr, slave1_addr, slave2_addr} <= {4{~a}};
    instr_addr <= ~a[23:0];
    {slave2_valid, slave1_valid, instr_valid, data_valid, progmem_valid} <= '0;
    {progmem_write, data_write, slave1_write, slave2_write} <= {4{~w}};
  endtask
  // Single-cycle illegal opcode pulse with its qualifiers
  task automatic fault(input logic [23:0] pc, input logic at);
    @(posedge aclk);
    {bad_opcode_irq, bad_opcode_pc, atomic_active} <= {1'b1, pc, at};
    @(posedge aclk);
    {bad_opcode_irq, bad_opcode_pc, atomic_active} <= {1'b0, ~pc, ~at};
  endtask
  task automatic decode(input logic [31:0] d1, input logic [31:0] d2);
    @(posedge aclk);
    {decode1_addr, decode2_addr} <= {d1, d2};
  endtask
endmodule
`default_nettype wire

// [test/tb_top.sv]
// Self-checking bench for the breakpoint debug unit
`timescale 1ns/1ps
`default_nettype none
`include "dbg_consts.vh"
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin mismatches++; \
  $display("mismatch at %0t: got %h want %h", $time, a, b); end end
module tb_top;
  localparam logic [31:0] CORE_IX = 32'h00000005; // Arbitrary index
  localparam logic [1:0]  OK = `RESP_OKAY;
  localparam logic [1:0]  ER = `RESP_SLVERR;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_rready;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, seed, v, lo, hi, a;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, decode1_addr, decode2_addr;
  logic [31:0] data_mem_addr, prog_mem_data_addr, slave1_addr, slave2_addr;
  logic [23:0] instr_addr, bad_opcode_pc;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, break_req, instr_valid, data_valid, data_write;
  logic progmem_valid, progmem_write, slave1_valid, slave1_write;
  logic slave2_valid, slave2_write, user_mode, bad_opcode_irq;
  logic atomic_active, e;
  int   mismatches, compares;
  core_breakpoint_debug_unit #(.CORE_INDEX(CORE_IX)) dut (.aclk, .aresetn,
    .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .instr_addr, .instr_valid,
    .data_mem_addr, .data_valid, .data_write, .prog_mem_data_addr,
    .progmem_valid, .progmem_write, .slave1_addr, .slave1_valid,
    .slave1_write, .slave2_addr, .slave2_valid, .slave2_write, .user_mode,
    .decode1_addr, .decode2_addr, .bad_opcode_irq, .bad_opcode_pc,
    .atomic_active, .break_req);
  core_model core (.aclk, .instr_addr, .instr_valid, .data_mem_addr,
    .data_valid, .data_write, .prog_mem_data_addr, .progmem_valid,
    .progmem_write, .slave1_addr, .slave1_valid, .slave1_write,
    .slave2_addr, .slave2_valid, .slave2_write, .user_mode, .decode1_addr,
    .decode2_addr, .bad_opcode_irq, .bad_opcode_pc, .atomic_active);
  // ********************************************************
  // Helpers
  // ********************************************************
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Units: 0 prog, 1-2 data, 3-6 instr, 7-8 slave
  function automatic int enb(int u);
    return u == 0 ? 19 : u < 3 ? 20 : u < 7 ? 21 : u == 7 ? 27 : 26;
  endfunction
  function automatic logic [4:0] bus(int u);
    return u == 0 ? 5'h01 : u < 3 ? 5'h02 : u < 7 ? 5'h04 : u == 7 ? 5'h08
         : 5'h10;
  endfunction
  function automatic logic [7:0] rofs(int u);
    return 8'(`OFS_RANGE_BASE + 8 * u);
  endfunction
  // Instruction units have no trigger field and always fire
  function automatic logic [31:0] ctl_of(int u, logic [1:0] t, logic n);
    ctl_of = (32'h1 << enb(u)) | (32'(n) << (u > 6 ? 17 : u + 10));
    if (u < 3 || u > 6)
      ctl_of = ctl_of | (32'(t) << (u == 0 ? 0 : u < 3 ? 2 * u : 6));
  endfunction
  task automatic wr(input logic [7:0] ad, input logic [31:0] d,
                    input logic [1:0] er);
    logic ta, tw, dn;
    logic [1:0] r;
    dn = 0;
    @(posedge aclk);
    {s_axi_awaddr, s_axi_wdata} <= {ad, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    while (!dn) begin
      @(negedge aclk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      {dn, r} = {s_axi_bvalid, s_axi_bresp};
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    `CHK(r, er)
  endtask
  task automatic rd(input logic [7:0] ad, input logic [31:0] ed,
                    input logic [1:0] er);
    logic ta, dn;
    logic [1:0] r;
    logic [31:0] d;
    dn = 0;
    @(posedge aclk);
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {ad, 2'h3};
    while (!dn) begin
      @(negedge aclk);
      ta = s_axi_arvalid && s_axi_arready;
      {dn, d, r} = {s_axi_rvalid, s_axi_rdata, s_axi_rresp};
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    `CHK({d, r}, {ed, er})
  endtask
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // ********************************************************
  // Stimulus
  // ********************************************************
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  // Whole run is under two thousand cycles; cut off well beyond that
  initial begin
    #500000;
    mismatches++;
    tally_and_finish();
  end
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
    {s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {seed, aresetn, mismatches, compares} = {32'h6, 1'b0, 64'h0};
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`OFS_BREAK_CONTROL, 32'h0, OK);
    rd(`OFS_BREAK_STATUS, 32'h0, OK);
    rd(`OFS_CORE_INDEX, CORE_IX, OK);
    wr(`OFS_BREAK_CONTROL, 32'hffffffff, OK);
    rd(`OFS_BREAK_CONTROL, `BC_WRITE_MASK, OK);
    wr(`OFS_BREAK_STATUS, 32'hffffffff, ER);
    wr(8'hfc, 32'h1, ER);
    rd(8'hfc, 32'h0, ER);
    $display("test registers done");
    // Each unit: trigger, direction and inversion at the range edge
    for (int u = 0; u < 9; u++) begin
      v = rnd();
      lo = (v & 32'h007fffff) + 1;
      hi = lo + v[31:28];
      wr(rofs(u), v, OK);
      rd(rofs(u), (u > 2 && u < 7) ? v & 32'h00ffffff : v, OK);
      wr(rofs(u), lo, OK);
      wr(rofs(u) + 8'h4, hi, OK);
      rd(rofs(u) + 8'h4, hi, OK);
      for (int k = 0; k < 16; k++) begin
        e = (u > 2 && u < 7) ? 1'b1 : k[k[2]];
        wr(`OFS_BREAK_CONTROL, ctl_of(u, k[1:0], k[3]), OK);
        core.access(bus(u), k[3] ? hi + 1 : hi, k[2], 1'b1);
        #1 `CHK(break_req, e)
        core.access(bus(u), k[3] ? hi : hi + 1, k[2], 1'b1);
        #1 `CHK(break_req, 1'b0)
        rd(`OFS_BREAK_STATUS, 32'(e) << (u == 8 ? 16 : u), OK);
      end
      wr(rofs(u), 32'hffffffff, OK);
      wr(rofs(u) + 8'h4, 32'h0, OK);
    end
    $display("test units done");
    a = 32'h00012340;
    for (int u = 0; u < 8; u = u + (u == 3 ? 4 : 3)) begin
      wr(rofs(u), a, OK);
      wr(rofs(u) + 8'h4, a, OK);
    end
    wr(`OFS_BREAK_CONTROL, 32'h090800c3, OK);
    core.access(5'h01, a, 1'b0, 1'b1);
    #1 `CHK(break_req, 1'b0)
    rd(`OFS_BREAK_STATUS, 32'h1, OK);
    core.access(5'h09, a, 1'b0, 1'b1);
    #1 `CHK(break_req, 1'b1)
    wr(`OFS_BREAK_CONTROL, 32'h02200000, OK);
    core.access(5'h04, a, 1'b0, 1'b0);
    #1 `CHK(break_req, 1'b0)
    core.access(5'h04, a, 1'b0, 1'b1);
    #1 `CHK(break_req, 1'b1)
    $display("test combine done");
    for (int k = 0; k < 2; k++) begin
      v = rnd();
      core.fault(v[23:0], k[0]);
      rd(`OFS_BAD_OPCODE, {7'h0, k[0], v[23:0]}, OK);
      wr(`OFS_BAD_OPCODE, v, OK);
      rd(`OFS_BAD_OPCODE, 32'h0, OK);
    end
    core.decode(v, ~v);
    rd(`OFS_DECODE1_ADDR, v, OK);
    rd(`OFS_DECODE2_ADDR, ~v, OK);
    $display("test capture done");
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`OFS_BREAK_STATUS, 32'h0, OK);
    rd(`OFS_BREAK_CONTROL, 32'h0, OK);
    $display("test reset done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
